/* psd_pkg.sv */
// package for controller start-up and diagnostics block
// assumes one 100 MHz system clock and an APB master
package psd_pkg;
	// ==========================================================
	// timing
	localparam int CLK_HZ = 100_000_000;
	localparam int BLINK_TIME_S = 3;
	localparam int BLINK_CYC = BLINK_TIME_S * CLK_HZ;
	localparam int TOGGLE_TIME_MS = 250;
	localparam int TOGGLE_CYC = TOGGLE_TIME_MS * (CLK_HZ / 1000);
	localparam int POR_WAIT = 3;
	// ==========================================================
	// register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_DSW = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0c;
	localparam logic [7:0] ADDR_MSG = 8'h10;
	localparam logic [7:0] ADDR_STN = 8'h14;
	// control bits
	localparam int CTRL_COLD = 0;
	localparam int CTRL_WARM = 1;
	localparam int CTRL_XBEG = 2;
	localparam int CTRL_XEND = 3;
	// config fields and reset value
	localparam int CFG_REC_LSB = 0;
	localparam int CFG_START_RUN = 2;
	localparam logic [2:0] CFG_RESET = 3'h0;
	localparam logic [1:0] REC_NONE = 2'h0;
	localparam logic [1:0] REC_WARM = 2'h1;
	localparam logic [1:0] REC_COLD = 2'h2;
	// selector positions
	localparam logic [1:0] SEL_HALT = 2'h0;
	localparam logic [1:0] SEL_RUN = 2'h1;
	localparam logic [1:0] SEL_MRST = 2'h2;
	localparam logic [15:0] DSW_RESET = 16'h0000;
	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE, ST_RUN, ST_FAULT, ST_COLD, ST_WARM, ST_COPY, ST_XFER
	} psd_state_e;
	typedef struct packed {
		logic reset_btn;
		logic [1:0] selector;
		logic battery_ok;
		logic module_fitted;
		logic bus_err;
	} psd_pins_s;
	typedef struct packed {
		logic idle;
		logic run;
		logic fault;
		logic battery;
	} psd_lamps_s;
endpackage : psd_pkg

/* psd_start_diag.sv */
// start-up, lamp and diagnostic status logic of the controller
// assumes operator pins are asynchronous, cpu-side signals share clk_i
//
// Notes on behaviour
// - cold start clears data, restarts program
// - cold on button, power-on, or host
// - fault exit at run may cold start
// - new program needs cold start first
// - warm finishes cycle with outputs zero
// - warm start keeps retentive data areas
// - warm on button, battery power-on, or host
// - fault exit at run may warm start
// - transfer only when idle or faulted
// - halt transfer lights idle and fault lamps
// - transfer writes ram and fitted module
// - power-on with module copies then starts (here it cold starts only with CFG_START_RUN set, else it copies then idles)
// - idle lamp on, blinks on bus error
// - fault lamp shows program or cpu error
// - battery lamp shows battery fault
// - 16-bit status word, two flag halves
// - indication flags never change the state
// - error flag set forces the fault state, except in transfer
// - station diagnostic bytes are read-only
// - read-only message byte reports status
// - every start copies module on mismatch
// - idle keeps outputs reset and disabled
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module psd_start_diag #(
	parameter int BLINK_CYCLES = psd_pkg::BLINK_CYC,
	parameter int TOGGLE_CYCLES = psd_pkg::TOGGLE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire psd_pkg::psd_pins_s pins_i,
	input wire logic self_test_ok_i,
	input wire logic prog_valid_i,
	input wire logic prog_match_i,
	input wire logic copy_done_i,
	input wire logic clear_done_i,
	input wire logic cycle_end_i,
	input wire logic [7:0] diag_ind_i,
	input wire logic [7:0] diag_err_i,
	input wire logic [31:0] station_diag_i,
	output psd_pkg::psd_lamps_s lamps_o,
	output logic clear_data_o,
	output logic restart_o,
	output logic outputs_zero_o,
	output logic reinit_o,
	output logic out_en_o,
	output logic ram_wr_en_o,
	output logic module_wr_en_o,
	output logic copy_o
);
	import psd_pkg::*;

	// ==========================================================
	// pin synchronisers
	psd_pins_s pin_meta_ff, pin_ff;
	logic btn_q_ff;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_meta_ff <= '0;
			pin_ff <= '0;
			btn_q_ff <= 1'b0;
		end else begin
			pin_meta_ff <= pins_i;
			pin_ff <= pin_meta_ff;
			btn_q_ff <= pin_ff.reset_btn;
		end
	end
	logic press;
	assign press = pin_ff.reset_btn & ~btn_q_ff;

	// ==========================================================
	// apb slave, one wait state
	logic [2:0] cfg_ff;
	logic [15:0] dsw_ff;
	logic [3:0] cmd_ff;
	psd_state_e state_ff, nxt_state;
	logic new_prog_ff, last_cold_ff, start_pend_ff;
	logic acc, wr_en, hit;
	assign acc = psel_i & penable_i;
	assign wr_en = acc & pready_o & pwrite_i;
	always_comb begin
		hit = 1'b1;
		case (paddr_i)
			ADDR_CTRL, ADDR_CFG, ADDR_DSW, ADDR_STAT, ADDR_MSG, ADDR_STN: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	logic [31:0] rd_mux;
	always_comb begin
		case (paddr_i)
			ADDR_CFG: rd_mux = {29'h0, cfg_ff};
			ADDR_DSW: rd_mux = {16'h0, dsw_ff};
			ADDR_STAT: rd_mux = {25'h0, new_prog_ff, 2'h0, lamps_o};
			ADDR_MSG: rd_mux = {24'h0, 1'b0, last_cold_ff, pin_ff.module_fitted,
				pin_ff.battery_ok, 1'b0, state_ff};
			ADDR_STN: rd_mux = station_diag_i;
			default: rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
			prdata_o <= 32'h0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= acc & ~pready_o;
			if (acc & ~pready_o) begin
				prdata_o <= pwrite_i ? 32'h0 : rd_mux;
				pslverr_o <= ~hit;
			end
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_ff <= CFG_RESET;
			cmd_ff <= 4'h0;
		end else begin
			cmd_ff <= 4'h0;
			if (wr_en && paddr_i == ADDR_CFG) begin
				cfg_ff <= pwdata_i[2:0];
			end
			if (wr_en && paddr_i == ADDR_CTRL) begin
				cmd_ff <= pwdata_i[3:0];
			end
		end
	end

	// ==========================================================
	// diagnostic status word
	logic [15:0] dsw_set, dsw_clr;
	logic err_new;
	always_comb begin
		// indications only when running or idle
		dsw_set[7:0] = (state_ff == ST_RUN || state_ff == ST_IDLE) ? diag_ind_i : 8'h0;
		dsw_set[15:8] = diag_err_i;
		dsw_clr = press ? 16'hffff : 16'h0000;
	end
	assign err_new = |(diag_err_i & ~dsw_ff[15:8]);
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dsw_ff <= DSW_RESET;
		end else begin
			dsw_ff <= (dsw_ff & ~dsw_clr) | dsw_set;
		end
	end

	// ==========================================================
	// power-on start
	logic [1:0] por_cnt_ff;
	logic por_pend_ff, por_fire;
	assign por_fire = por_pend_ff && por_cnt_ff == 2'(POR_WAIT);
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			por_cnt_ff <= 2'h0;
			por_pend_ff <= 1'b1;
		end else if (por_fire) begin
			por_pend_ff <= 1'b0;
		end else if (por_pend_ff) begin
			por_cnt_ff <= por_cnt_ff + 2'h1;
		end
	end

	// ==========================================================
	// start decision
	logic idle_or_flt, sel_run, sel_mrst, sel_halt;
	logic cold_req, warm_req, halt_req, start_req, kind_cold, copy_need;
	logic [1:0] rec;
	assign rec = cfg_ff[CFG_REC_LSB +: 2];
	assign idle_or_flt = state_ff == ST_IDLE || state_ff == ST_FAULT;
	assign sel_run = pin_ff.selector == SEL_RUN;
	assign sel_mrst = pin_ff.selector == SEL_MRST;
	assign sel_halt = pin_ff.selector == SEL_HALT;
	always_comb begin
		cold_req = (press & sel_mrst & idle_or_flt) | (cmd_ff[CTRL_COLD] & idle_or_flt);
		cold_req = cold_req | (press & sel_run & state_ff == ST_FAULT & rec == REC_COLD);
		warm_req = (press & sel_run & state_ff == ST_IDLE) |
			(cmd_ff[CTRL_WARM] & state_ff == ST_IDLE);
		warm_req = warm_req | (press & sel_run & state_ff == ST_FAULT & rec == REC_WARM);
		if (por_fire) begin
			if (pin_ff.module_fitted) begin
				cold_req = cfg_ff[CFG_START_RUN];
				warm_req = 1'b0;
			end else begin
				cold_req = sel_mrst;
				warm_req = sel_run & pin_ff.battery_ok;
			end
		end
		if (new_prog_ff) begin
			warm_req = 1'b0;
		end
		if (!prog_valid_i && !pin_ff.module_fitted) begin
			cold_req = 1'b0;
			warm_req = 1'b0;
		end
		halt_req = press & sel_halt & (state_ff == ST_RUN || state_ff == ST_FAULT);
		start_req = cold_req | warm_req;
		kind_cold = cold_req;
		copy_need = pin_ff.module_fitted & (~prog_match_i | (por_fire & start_req));
	end

	// ==========================================================
	// operating state machine
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE, ST_FAULT: begin
				// transfer only from idle or fault
				if (cmd_ff[CTRL_XBEG]) begin
					nxt_state = ST_XFER;
				end else if (start_req) begin
					nxt_state = copy_need ? ST_COPY : (kind_cold ? ST_COLD : ST_WARM);
				end else if (halt_req || (por_fire && pin_ff.module_fitted)) begin
					nxt_state = pin_ff.module_fitted && por_fire ? ST_COPY : ST_IDLE;
				end
			end
			ST_RUN: begin
				if (halt_req) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_COPY: begin
				if (copy_done_i) begin
					nxt_state = ~start_pend_ff ? ST_IDLE : (last_cold_ff ? ST_COLD : ST_WARM);
				end
			end
			ST_COLD: begin
				if (clear_done_i) begin
					nxt_state = ST_RUN;
				end
			end
			ST_WARM: begin
				if (cycle_end_i) begin
					nxt_state = ST_RUN;
				end
			end
			ST_XFER: begin
				if (cmd_ff[CTRL_XEND]) begin
					nxt_state = ST_FAULT;
				end
			end
			default: nxt_state = ST_FAULT;
		endcase
		if (err_new && state_ff != ST_XFER) begin
			nxt_state = ST_FAULT;
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= ST_IDLE;
			last_cold_ff <= 1'b0;
			start_pend_ff <= 1'b0;
			new_prog_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (idle_or_flt && nxt_state == ST_COPY) begin
				last_cold_ff <= kind_cold;
				start_pend_ff <= start_req;
			end else if (idle_or_flt && (nxt_state == ST_COLD || nxt_state == ST_WARM)) begin
				last_cold_ff <= kind_cold;
			end
			if (state_ff == ST_XFER && cmd_ff[CTRL_XEND]) begin
				new_prog_ff <= 1'b1;
			end else if (state_ff == ST_COLD && clear_done_i) begin
				new_prog_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// action outputs
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clear_data_o <= 1'b0;
			restart_o <= 1'b0;
			outputs_zero_o <= 1'b0;
			reinit_o <= 1'b0;
			out_en_o <= 1'b0;
			ram_wr_en_o <= 1'b0;
			module_wr_en_o <= 1'b0;
			copy_o <= 1'b0;
		end else begin
			clear_data_o <= nxt_state == ST_COLD;
			restart_o <= state_ff == ST_COLD && nxt_state == ST_RUN;
			outputs_zero_o <= nxt_state == ST_WARM;
			reinit_o <= state_ff == ST_WARM && nxt_state == ST_RUN;
			out_en_o <= nxt_state == ST_RUN;
			ram_wr_en_o <= nxt_state == ST_XFER;
			module_wr_en_o <= nxt_state == ST_XFER && pin_ff.module_fitted;
			copy_o <= nxt_state == ST_COPY;
		end
	end

	// ==========================================================
	// lamps
	logic [31:0] blink_cnt_ff, tog_cnt_ff;
	logic blink_ph_ff, bus_err_q_ff;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			blink_cnt_ff <= 32'h0;
			tog_cnt_ff <= 32'h0;
			blink_ph_ff <= 1'b0;
			bus_err_q_ff <= 1'b0;
		end else begin
			bus_err_q_ff <= pin_ff.bus_err;
			if (pin_ff.bus_err && !bus_err_q_ff) begin
				blink_cnt_ff <= 32'(BLINK_CYCLES);
				tog_cnt_ff <= 32'h0;
			end else if (blink_cnt_ff != 32'h0) begin
				blink_cnt_ff <= blink_cnt_ff - 32'h1;
				if (tog_cnt_ff == 32'(TOGGLE_CYCLES - 1)) begin
					tog_cnt_ff <= 32'h0;
					blink_ph_ff <= ~blink_ph_ff;
				end else begin
					tog_cnt_ff <= tog_cnt_ff + 32'h1;
				end
			end else begin
				blink_ph_ff <= 1'b0;
			end
		end
	end
	logic xfer_halt;
	assign xfer_halt = nxt_state == ST_XFER && sel_halt;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lamps_o <= '0;
		end else begin
			lamps_o.idle <= xfer_halt | (blink_cnt_ff != 32'h0 ? blink_ph_ff :
				self_test_ok_i & nxt_state == ST_IDLE);
			lamps_o.run <= nxt_state == ST_RUN;
			lamps_o.fault <= xfer_halt | nxt_state == ST_FAULT | ~prog_valid_i;
			lamps_o.battery <= ~pin_ff.battery_ok;
		end
	end

	// ==========================================================
	// checks
	chk_err_to_fault: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		err_new && state_ff != ST_XFER |=> state_ff == ST_FAULT)
		else $error("error flag did not force fault");
	chk_xfer_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(state_ff == ST_XFER) |-> $past(state_ff) inside {ST_IDLE, ST_FAULT})
		else $error("transfer entered from wrong state");
	chk_warm_no_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_ff == ST_WARM |=> !clear_data_o || state_ff == ST_COLD)
		else $error("warm start cleared data");
	chk_cold_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_ff == ST_COLD && clear_done_i && !err_new |=> restart_o && out_en_o)
		else $error("cold start missed restart");
	chk_new_prog_cold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		new_prog_ff |-> state_ff != ST_WARM)
		else $error("warm start with new program");
	chk_idle_outputs: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_ff == ST_IDLE |=> ##1 !out_en_o || $past(state_ff) != ST_IDLE)
		else $error("outputs enabled in idle");
	chk_warm_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_ff == ST_WARM && !cycle_end_i && !err_new |=> outputs_zero_o)
		else $error("outputs not zero in warm remainder");
	chk_dsw_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		diag_err_i != 8'h00 |=> (dsw_ff[15:8] & $past(diag_err_i)) == $past(diag_err_i))
		else $error("error flag not captured");
	chk_battery_lamp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!pin_ff.battery_ok |=> lamps_o.battery)
		else $error("battery lamp not lit");
	chk_module_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_ff == ST_XFER && pin_ff.module_fitted && !cmd_ff[CTRL_XEND] && !err_new
		|=> ram_wr_en_o && module_wr_en_o)
		else $error("transfer did not write module");
endmodule : psd_start_diag

/* psd_ctl_model.sv */
// far-side model: cpu core, memory module copy and data clearing engine
// assumes the block's clock and level requests held until acknowledged
`timescale 1ns/10ps
module psd_ctl_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] dly_i,
	input wire logic copy_i,
	input wire logic clear_i,
	input wire logic zero_i,
	output logic copy_done_o,
	output logic clear_done_o,
	output logic cycle_end_o
);
	// ==========================================================
	// request age counter, prompt or slow by dly_i
	logic [3:0] cnt_ff;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= 4'h0;
		end else if (!(copy_i | clear_i | zero_i)) begin
			cnt_ff <= 4'h0;
		end else if (cnt_ff != 4'hf) begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end
	// ==========================================================
	// acknowledges, low while no request stands
	// module copy finished
	assign copy_done_o = copy_i && (cnt_ff >= dly_i);
	assign clear_done_o = clear_i && (cnt_ff >= dly_i);
	assign cycle_end_o = zero_i && (cnt_ff >= dly_i);
endmodule : psd_ctl_model

/* psd_start_diag_tb.sv */
// self-checking bench for the start-up and diagnostics block
// assumes the far-side model answers copy, clear and cycle requests
`timescale 1ns/10ps
module psd_start_diag_tb;
	import psd_pkg::*;
	// ==========================================================
	// signals
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	psd_pins_s pins = '{1'b0, SEL_HALT, 1'b1, 1'b0, 1'b0};
	logic [7:0] d_ind = 8'h00;
	logic [7:0] d_err = 8'h00;
	logic [3:0] dly = 4'h6;
	logic pvalid = 1'b1;
	logic pmatch = 1'b1;
	logic copy_done, clear_done, cyc_end;
	psd_lamps_s lamps;
	logic clear_data, restart, zero, reinit, out_en, ram_wr, mod_wr, copy;
	int failures = 0;
	int checks_done = 0;
	logic [31:0] rd;
	logic err;
	int low;
	typedef struct packed {
		logic w;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic e;
	} psd_row_s;
	psd_row_s rows [9] = '{
		{1'b0, ADDR_CFG, 32'h0, 32'h0, 1'b0},
		{1'b0, ADDR_DSW, 32'h0, 32'h0, 1'b0},
		{1'b0, ADDR_STN, 32'h0, 32'h5a3c0f11, 1'b0},
		{1'b1, ADDR_STN, 32'hffffffff, 32'h0, 1'b0},
		{1'b0, ADDR_STN, 32'h0, 32'h5a3c0f11, 1'b0},
		{1'b1, ADDR_DSW, 32'hffffffff, 32'h0, 1'b0},
		{1'b0, ADDR_DSW, 32'h0, 32'h0, 1'b0},
		{1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
		{1'b0, ADDR_MSG, 32'h0, 32'h10, 1'b0}
	};
	always #5 clk_i = ~clk_i;
	psd_ctl_model model (.clk_i(clk_i), .rst_n_i(rst_n_i), .dly_i(dly), .copy_i(copy),
		.clear_i(clear_data), .zero_i(zero), .copy_done_o(copy_done),
		.clear_done_o(clear_done), .cycle_end_o(cyc_end));
	psd_start_diag #(.BLINK_CYCLES(40), .TOGGLE_CYCLES(4)) dut (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .pins_i(pins), .self_test_ok_i(1'b1), .prog_valid_i(pvalid),
		.prog_match_i(pmatch), .copy_done_i(copy_done), .clear_done_i(clear_done),
		.cycle_end_i(cyc_end), .diag_ind_i(d_ind), .diag_err_i(d_err),
		.station_diag_i(32'h5a3c0f11), .lamps_o(lamps), .clear_data_o(clear_data),
		.restart_o(restart), .outputs_zero_o(zero), .reinit_o(reinit), .out_en_o(out_en),
		.ram_wr_en_o(ram_wr), .module_wr_en_o(mod_wr), .copy_o(copy));
	// ==========================================================
	// tasks
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			failures++;
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			chk(32'h0, 32'h1);
			print_verdict();
		end
	endtask : apb
	task automatic wait_pulse(input logic [1:0] which);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (((which == 2'd2 ? copy : which[0] ? reinit : restart) !== 1'b1) && n < 60);
		if (n >= 60) begin
			chk(32'h0, 32'h1);
			print_verdict();
		end
	endtask : wait_pulse
	task automatic msg_is(input logic [2:0] st);
		apb(1'b0, ADDR_MSG, 32'h0);
		chk({29'h0, rd[2:0]}, {29'h0, st});
	endtask : msg_is
	task automatic press_btn();
		pins.reset_btn <= 1'b1;
		cyc(4);
		pins.reset_btn <= 1'b0;
		cyc(6);
	endtask : press_btn
	task automatic do_reset();
		rst_n_i <= 1'b0;
		cyc(3);
		rst_n_i <= 1'b1;
	endtask : do_reset
	// ==========================================================
	// main sequence
	initial begin
		cyc(2);
		chk({24'h0, lamps, clear_data, restart, zero, reinit}, 32'h0);
		cyc(1);
		rst_n_i <= 1'b1;
		cyc(10);
		for (int i = 0; i < 9; i++) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) begin
				chk(rd, rows[i].x);
			end
			chk({31'h0, err}, {31'h0, rows[i].e});
		end
		$display("test registers done");
		apb(1'b1, ADDR_CTRL, 32'h1);
		cyc(3);
		chk({31'h0, clear_data}, 32'h1);
		wait_pulse(2'd0);
		chk({31'h0, out_en}, 32'h1);
		msg_is(3'h1);
		$display("test host cold done");
		d_ind <= 8'h05;
		apb(1'b1, ADDR_CTRL, 32'h1);
		cyc(3);
		chk({31'h0, clear_data}, 32'h0);
		msg_is(3'h1);
		d_err <= 8'h80;
		cyc(4);
		msg_is(3'h2);
		chk({31'h0, lamps.fault}, 32'h1);
		apb(1'b0, ADDR_DSW, 32'h0);
		chk(rd, 32'h8005);
		d_err <= 8'h00;
		d_ind <= 8'h00;
		$display("test fault entry done");
		apb(1'b1, ADDR_CTRL, 32'h4);
		cyc(3);
		chk({30'h0, ram_wr, mod_wr}, 32'h2);
		chk({30'h0, lamps.idle, lamps.fault}, 32'h3);
		apb(1'b1, ADDR_CTRL, 32'h8);
		press_btn();
		apb(1'b1, ADDR_CTRL, 32'h2);
		cyc(3);
		msg_is(3'h0);
		dly <= 4'h1;
		apb(1'b1, ADDR_CTRL, 32'h1);
		wait_pulse(2'd0);
		msg_is(3'h1);
		$display("test transfer done");
		press_btn();
		msg_is(3'h0);
		chk({31'h0, out_en}, 32'h0);
		apb(1'b0, ADDR_DSW, 32'h0);
		chk(rd, 32'h0);
		dly <= 4'h3;
		apb(1'b1, ADDR_CTRL, 32'h2);
		cyc(3);
		chk({31'h0, zero}, 32'h1);
		wait_pulse(2'd1);
		chk({31'h0, out_en}, 32'h1);
		msg_is(3'h1);
		$display("test warm start done");
		pins.battery_ok <= 1'b0;
		cyc(6);
		chk({31'h0, lamps.battery}, 32'h1);
		pins.battery_ok <= 1'b1;
		cyc(6);
		chk({31'h0, lamps.battery}, 32'h0);
		$display("test battery done");
		d_err <= 8'h01;
		cyc(4);
		msg_is(3'h2);
		d_err <= 8'h00;
		apb(1'b1, ADDR_CFG, {30'h0, REC_WARM});
		pins.selector <= SEL_RUN;
		press_btn();
		apb(1'b0, ADDR_MSG, 32'h0);
		chk(rd, 32'h11);
		d_err <= 8'h02;
		cyc(4);
		msg_is(3'h2);
		d_err <= 8'h00;
		apb(1'b1, ADDR_CFG, {30'h0, REC_COLD});
		press_btn();
		apb(1'b0, ADDR_MSG, 32'h0);
		chk(rd, 32'h51);
		$display("test fault recovery done");
		pins.selector <= SEL_HALT;
		press_btn();
		pvalid <= 1'b0;
		cyc(2);
		chk({31'h0, lamps.fault}, 32'h1);
		apb(1'b1, ADDR_CTRL, 32'h1);
		cyc(3);
		msg_is(3'h0);
		pvalid <= 1'b1;
		$display("test program missing done");
		pins.bus_err <= 1'b1;
		low = 0;
		repeat (44) begin
			@(posedge clk_i);
			if (!lamps.idle) begin
				low++;
			end
		end
		chk({31'h0, low != 0}, 32'h1);
		cyc(10);
		chk({31'h0, lamps.idle}, 32'h1);
		pins.bus_err <= 1'b0;
		$display("test blink done");
		pins.module_fitted <= 1'b1;
		pins.selector <= SEL_MRST;
		do_reset();
		wait_pulse(2'd2);
		cyc(10);
		apb(1'b0, ADDR_MSG, 32'h0);
		chk(rd, 32'h30);
		apb(1'b1, ADDR_CTRL, 32'h4);
		cyc(3);
		chk({30'h0, ram_wr, mod_wr}, 32'h3);
		apb(1'b1, ADDR_CTRL, 32'h8);
		pmatch <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h1);
		wait_pulse(2'd2);
		wait_pulse(2'd0);
		pmatch <= 1'b1;
		msg_is(3'h1);
		$display("test memory module done");
		pins.module_fitted <= 1'b0;
		do_reset();
		wait_pulse(2'd0);
		apb(1'b0, ADDR_MSG, 32'h0);
		chk(rd, 32'h51);
		pins.selector <= SEL_RUN;
		do_reset();
		wait_pulse(2'd1);
		msg_is(3'h1);
		$display("test power-on starts done");
		print_verdict();
	end
endmodule : psd_start_diag_tb
